// File: autobaud_timer.sv
// Counts the autobaud window in core clock cycles and pulses on expiry.
// Restart must be pulsed on entry to the window.
`timescale 1ns/1ps
module autobaud_timer
	import isp_boot_pkg::*;
#(
	parameter int unsigned CYCLES = AUTOBAUD_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic restart_i,
	input wire logic run_i,
	output logic timeout_o
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	logic [CW-1:0] cnt_q, cnt_d;
	logic tmo_q, tmo_d;

	always_comb begin
		cnt_d = cnt_q;
		tmo_d = 1'b0;
		if (restart_i) begin
			cnt_d = '0; // RULE25
		end else if (run_i) begin
			if (cnt_q == LAST) begin
				tmo_d = 1'b1;
				cnt_d = '0;
			end else begin
				cnt_d = CW'(cnt_q + 1'b1);
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			tmo_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tmo_q <= tmo_d;
		end
	end

	assign timeout_o = tmo_q;
endmodule

// File: host_model.sv
// Host programmer model driving the loader byte link.
// Assumes the block samples host bytes on rising core_clk_i edges.
`timescale 1ns/1ps
module host_model
	import isp_boot_pkg::*;
(
	input wire logic core_clk_i,
	output logic host_byte_valid_o,
	output logic [7:0] host_byte_o
);
	initial begin
		host_byte_valid_o = 1'b0;
		host_byte_o = 8'h00;
	end
	// Idle data is the inverse of the last byte so a stale value never looks fresh
	task automatic send(input logic [7:0] b);
		@(posedge core_clk_i);
		host_byte_valid_o <= 1'b1;
		host_byte_o <= b;
		@(posedge core_clk_i);
		host_byte_valid_o <= 1'b0;
		host_byte_o <= ~b;
	endtask
	// Command then 32 bytes back to back, low byte of each word first
	task automatic send_pwd(input logic [255:0] p);
		@(posedge core_clk_i);
		host_byte_valid_o <= 1'b1;
		host_byte_o <= CMD_PWD;
		for (int n = 0; n < 32; n++) begin
			@(posedge core_clk_i);
			host_byte_o <= p[8*n+:8];
		end
		@(posedge core_clk_i);
		host_byte_valid_o <= 1'b0;
		host_byte_o <= ~p[255:248];
	endtask
endmodule

// File: isp_boot_pkg.sv
// Constants, encodings and timing for the boot-source and loader control block.
// Assumes a single 25 MHz core clock and synchronous resets on that clock.
//
// Notes on behaviour
// [RULE1] After any reset, fetch starts at ROM.
// [RULE2] Program enable with source 00 selects JTAG.
// [RULE3] Password set, no JTAG request: run application.
// [RULE4] No password: wait five seconds for CR.
// [RULE5] No autobaud character in time: run application.
// [RULE6] Autobaud seen: UART loader, send prompt.
// [RULE7] Family zero always; others need lock clear.
// [RULE8] Family zero never exposes memory contents.
// [RULE9] Password command plus 32 bytes clears lock.
// [RULE10] Wrong password while unlocked sets lock again.
// [RULE11] Master erase wipes flash, unlocks all commands.
// [RULE12] Exit: application if password, else rewait.
// [RULE13] Lock cleared by software opens all commands.
// [RULE14] Source bits three, two; need program enable.
// [RULE15] Source read is CPU copy OR TAP copy.
// [RULE16] CPU source bits cleared by POR or TLR.
// [RULE17] CPU flag writes clear TAP source copy.
// [RULE18] Program enable read is CPU OR TAP.
// [RULE19] Program enable zero: application; one: loader. With program enable and a reserved source the code runs the application.
// [RULE20] CPU program enable cleared only POR, TLR.
// [RULE21] ROM done set clears TAP program enable.
// [RULE22] Source 00 JTAG, 01 UART, rest reserved.
// [RULE23] ROM done with program enable resets system.
// [RULE24] Lock comes out of POR set.
// [RULE25] Autobaud window counted on core clock, restarted.
// [RULE26] Flag bits seven to four read zero.
package isp_boot_pkg;
	localparam logic [7:0] OFS_FLAGS = 8'h1B;
	localparam logic [7:0] OFS_SYSCTL = 8'h08;
	localparam int BIT_XFER = 0;
	localparam int BIT_SPE = 1;
	localparam int BIT_PSS_LO = 2;
	localparam int BIT_PSS_HI = 3;
	localparam int SC_BIT_LOCK = 1;
	localparam int SC_BIT_ROD = 2;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic LOCK_POR = 1'b1;
	localparam logic [15:0] ROM_START = 16'h8000;
	localparam logic [15:0] APP_START = 16'h0000;
	localparam logic [7:0] AUTOBAUD_CHAR = 8'h0D;
	localparam logic [7:0] PROMPT_CHAR = 8'h3E;
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_EXIT = 8'h01;
	localparam logic [7:0] CMD_ERASE = 8'h02;
	localparam logic [7:0] CMD_PWD = 8'h03;
	localparam logic [7:0] CMD_STATUS = 8'h04;
	localparam logic [5:0] PWD_BYTES = 6'h20;
	localparam logic [1:0] SRC_JTAG = 2'h0;
	localparam logic [1:0] SRC_UART = 2'h1;
	localparam logic [7:0] STAT_OK = 8'h00;
	localparam logic [7:0] STAT_BAD_CMD = 8'h02;
	localparam logic [7:0] STAT_NO_PWD = 8'h03;
	localparam logic [7:0] STAT_NO_BAUD = 8'h09;
	localparam int unsigned AUTOBAUD_S = 5;
	localparam int unsigned CORE_CLK_HZ = 25000000;
	localparam int unsigned AUTOBAUD_CYCLES = AUTOBAUD_S * CORE_CLK_HZ;
	typedef enum logic [2:0] {
		ST_ROM = 3'h0,
		ST_CHECK = 3'h1,
		ST_WAIT_BAUD = 3'h2,
		ST_LOADER = 3'h3,
		ST_PWD = 3'h4,
		ST_APP = 3'h5,
		ST_ERASE = 3'h6,
		ST_FWD = 3'h7
	} boot_state_e;
endpackage

// File: isp_boot_source_control.sv
// Boot-path sequencer, loader command gate and programming flag register.
// Assumes host bytes, TAP buffer writes and CPU accesses all arrive on core_clk_i.
`timescale 1ns/1ps
module isp_boot_source_control
	import isp_boot_pkg::*;
#(
	parameter int unsigned BAUD_WAIT_CYCLES = AUTOBAUD_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic tlr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic tap_pss_wr_i,
	input wire logic [1:0] tap_pss_i,
	input wire logic tap_spe_wr_i,
	input wire logic tap_spe_i,
	input wire logic rod_clear_i,
	input wire logic [255:0] stored_pwd_i,
	input wire logic host_byte_valid_i,
	input wire logic [7:0] host_byte_i,
	input wire logic cmd_done_i,
	input wire logic erase_done_i,
	output logic [15:0] exec_addr_o,
	output logic app_run_o,
	output logic loader_active_o,
	output logic [1:0] loader_src_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic cmd_fwd_valid_o,
	output logic [7:0] cmd_fwd_byte_o,
	output logic erase_req_o,
	output logic [7:0] status_o,
	output logic pass_lock_flag_o,
	output logic sys_reset_req_o
);
	// ------------------------------------------------------------
	// Programming flag and control registers
	// ------------------------------------------------------------
	logic sys_rst;
	logic flag_rst;
	logic [1:0] cpu_pss_q, cpu_pss_d;
	logic cpu_spe_q, cpu_spe_d;
	logic xfer_q, xfer_d;
	logic [1:0] tap_pss_q, tap_pss_d;
	logic tap_spe_q, tap_spe_d;
	logic rod_q, rod_d;
	logic lock_q, lock_d;
	logic [7:0] rdata_q, rdata_d;
	logic sysrst_q, sysrst_d;
	logic [1:0] pss_rd;
	logic spe_rd;
	logic wr_flags;
	logic wr_sc;
	logic rod_set;
	logic pwd_ok;
	logic pwd_bad;
	logic pwd_set;
	logic [7:0] flags_view;
	boot_state_e state_q, state_d;

	pwd_if pw();

	assign sys_rst = rst_i | por_i;
	assign flag_rst = por_i | tlr_i;
	assign wr_flags = reg_wr_i && reg_addr_i == OFS_FLAGS;
	assign wr_sc = reg_wr_i && reg_addr_i == OFS_SYSCTL;
	assign pss_rd = cpu_pss_q | tap_pss_q; // RULE15
	assign spe_rd = cpu_spe_q | tap_spe_q; // RULE18
	assign rod_set = wr_sc && reg_wdata_i[SC_BIT_ROD] && !rod_q;
	assign pwd_ok = pw.done && pw.match;
	assign pwd_bad = pw.done && !pw.match;
	// All zeros or all ones in the password words counts as no password
	assign pwd_set = !(stored_pwd_i == '0 || stored_pwd_i == '1);

	always_comb begin
		flags_view = FLAGS_RESET; // RULE26
		flags_view[BIT_PSS_HI:BIT_PSS_LO] = pss_rd;
		flags_view[BIT_SPE] = spe_rd;
		flags_view[BIT_XFER] = xfer_q;
		cpu_pss_d = cpu_pss_q;
		cpu_spe_d = cpu_spe_q;
		xfer_d = xfer_q;
		tap_pss_d = tap_pss_q;
		tap_spe_d = tap_spe_q;
		rod_d = rod_q;
		lock_d = lock_q;
		rdata_d = 8'h00;
		if (wr_flags) begin
			cpu_pss_d = reg_wdata_i[BIT_PSS_HI:BIT_PSS_LO];
			cpu_spe_d = reg_wdata_i[BIT_SPE];
			xfer_d = reg_wdata_i[BIT_XFER];
			tap_pss_d = 2'h0; // RULE17
		end
		if (tap_pss_wr_i) begin
			tap_pss_d = tap_pss_i;
		end
		if (rod_clear_i) begin
			rod_d = 1'b0;
		end
		if (wr_sc) begin
			rod_d = reg_wdata_i[SC_BIT_ROD];
			lock_d = reg_wdata_i[SC_BIT_LOCK]; // RULE13
		end
		if (rod_set) begin
			tap_spe_d = 1'b0; // RULE21
		end
		if (tap_spe_wr_i) begin
			tap_spe_d = tap_spe_i;
		end
		if (pwd_ok || (state_q == ST_ERASE && erase_done_i)) begin
			lock_d = 1'b0; // RULE9 RULE11
		end
		if (pwd_bad) begin
			lock_d = 1'b1; // RULE10
		end
		if (reg_rd_i) begin
			if (reg_addr_i == OFS_FLAGS) begin
				rdata_d = flags_view;
			end else if (reg_addr_i == OFS_SYSCTL) begin
				rdata_d[SC_BIT_ROD] = rod_q;
				rdata_d[SC_BIT_LOCK] = lock_q;
			end
		end
		sysrst_d = rod_set && spe_rd; // RULE23
	end

	always_ff @(posedge core_clk_i) begin
		if (flag_rst) begin
			cpu_pss_q <= 2'h0; // RULE16
			cpu_spe_q <= 1'b0; // RULE20
			tap_pss_q <= 2'h0;
			tap_spe_q <= 1'b0;
		end else begin
			cpu_pss_q <= cpu_pss_d;
			cpu_spe_q <= cpu_spe_d;
			tap_pss_q <= tap_pss_d;
			tap_spe_q <= tap_spe_d;
		end
		if (por_i) begin
			lock_q <= LOCK_POR; // RULE24
		end else begin
			lock_q <= lock_d;
		end
		if (sys_rst || tlr_i) begin
			xfer_q <= 1'b0;
		end else begin
			xfer_q <= xfer_d;
		end
		if (sys_rst) begin
			rod_q <= 1'b0;
			rdata_q <= 8'h00;
			sysrst_q <= 1'b0;
		end else begin
			rod_q <= rod_d;
			rdata_q <= rdata_d;
			sysrst_q <= sysrst_d;
		end
	end

	// ------------------------------------------------------------
	// Boot sequencer and loader command gate
	// ------------------------------------------------------------
	logic [15:0] addr_q, addr_d;
	logic [1:0] src_q, src_d;
	logic tx_q, tx_d;
	logic fwd_q, fwd_d;
	logic [7:0] fwd_byte_q, fwd_byte_d;
	logic erase_q, erase_d;
	logic [7:0] stat_q, stat_d;
	logic baud_tmo;
	logic baud_restart;

	assign baud_restart = state_d == ST_WAIT_BAUD && state_q != ST_WAIT_BAUD; // RULE25

	autobaud_timer #(
		.CYCLES(BAUD_WAIT_CYCLES)
	) u_timer (
		.core_clk_i(core_clk_i),
		.rst_i(sys_rst),
		.restart_i(baud_restart),
		.run_i(state_q == ST_WAIT_BAUD),
		.timeout_o(baud_tmo)
	);

	pwd_compare u_cmp (
		.core_clk_i(core_clk_i),
		.rst_i(sys_rst),
		.stored_pwd_i(stored_pwd_i),
		.pw(pw)
	);

	assign pw.start = state_q == ST_LOADER && host_byte_valid_i && host_byte_i == CMD_PWD;
	assign pw.byte_valid = state_q == ST_PWD && host_byte_valid_i;
	assign pw.byte_data = host_byte_i;

	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		src_d = src_q;
		tx_d = 1'b0;
		fwd_d = 1'b0;
		fwd_byte_d = fwd_byte_q;
		erase_d = 1'b0;
		stat_d = stat_q;
		unique case (state_q)
			ST_ROM: begin
				state_d = ST_CHECK;
			end
			ST_CHECK: begin
				// Source bits only mean something with program enable set
				if (spe_rd && pss_rd == SRC_JTAG) begin
					src_d = SRC_JTAG; // RULE2 RULE14 RULE22
					state_d = ST_LOADER;
				end else if (spe_rd && pss_rd == SRC_UART) begin
					state_d = ST_WAIT_BAUD; // RULE19
				end else if (spe_rd || pwd_set) begin
					addr_d = APP_START; // RULE3
					state_d = ST_APP;
				end else begin
					state_d = ST_WAIT_BAUD; // RULE4
				end
			end
			ST_WAIT_BAUD: begin
				if (host_byte_valid_i && host_byte_i == AUTOBAUD_CHAR) begin
					src_d = SRC_UART; // RULE6
					tx_d = 1'b1;
					stat_d = STAT_OK;
					state_d = ST_LOADER;
				end else if (baud_tmo) begin
					stat_d = STAT_NO_BAUD;
					addr_d = APP_START; // RULE5
					state_d = ST_APP;
				end
			end
			ST_LOADER: begin
				if (host_byte_valid_i) begin
					if (host_byte_i[7:4] != 4'h0) begin
						if (lock_q) begin
							stat_d = STAT_NO_PWD; // RULE7
							tx_d = 1'b1;
						end else begin
							fwd_d = 1'b1;
							fwd_byte_d = host_byte_i;
							state_d = ST_FWD;
						end
					end else if (host_byte_i == CMD_NOP) begin
						stat_d = STAT_OK;
						tx_d = 1'b1;
					end else if (host_byte_i == CMD_EXIT) begin
						stat_d = STAT_OK;
						if (pwd_set) begin
							addr_d = APP_START; // RULE12
							state_d = ST_APP;
						end else begin
							state_d = ST_WAIT_BAUD;
						end
					end else if (host_byte_i == CMD_ERASE) begin
						erase_d = 1'b1; // RULE11
						state_d = ST_ERASE;
					end else if (host_byte_i == CMD_PWD) begin
						state_d = ST_PWD;
					end else if (host_byte_i == CMD_STATUS) begin
						// Status only carries flags and codes, never memory
						fwd_d = 1'b1; // RULE8
						fwd_byte_d = host_byte_i;
						state_d = ST_FWD;
					end else begin
						stat_d = STAT_BAD_CMD;
						tx_d = 1'b1;
					end
				end
			end
			ST_PWD: begin
				if (pw.done) begin
					stat_d = pw.match ? STAT_OK : STAT_NO_PWD;
					tx_d = 1'b1;
					state_d = ST_LOADER;
				end
			end
			ST_ERASE: begin
				if (erase_done_i) begin
					stat_d = STAT_OK;
					tx_d = 1'b1;
					state_d = ST_LOADER;
				end
			end
			ST_FWD: begin
				if (cmd_done_i) begin
					tx_d = 1'b1;
					state_d = ST_LOADER;
				end
			end
			ST_APP: begin
				state_d = ST_APP;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst) begin
			state_q <= ST_ROM;
			addr_q <= ROM_START; // RULE1
			src_q <= SRC_JTAG;
			tx_q <= 1'b0;
			fwd_q <= 1'b0;
			fwd_byte_q <= 8'h00;
			erase_q <= 1'b0;
			stat_q <= STAT_OK;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			src_q <= src_d;
			tx_q <= tx_d;
			fwd_q <= fwd_d;
			fwd_byte_q <= fwd_byte_d;
			erase_q <= erase_d;
			stat_q <= stat_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign exec_addr_o = addr_q;
	assign app_run_o = state_q == ST_APP;
	assign loader_active_o = state_q == ST_LOADER || state_q == ST_PWD || state_q == ST_ERASE || state_q == ST_FWD;
	assign loader_src_o = src_q;
	assign tx_valid_o = tx_q;
	assign tx_data_o = tx_q ? PROMPT_CHAR : 8'h00;
	assign cmd_fwd_valid_o = fwd_q;
	assign cmd_fwd_byte_o = fwd_byte_q;
	assign erase_req_o = erase_q;
	assign status_o = stat_q;
	assign pass_lock_flag_o = lock_q;
	assign sys_reset_req_o = sysrst_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_bad_pwd;
		pw.done && !pw.match;
	endsequence
	sequence s_lock_set;
		lock_q;
	endsequence
	property p_rom_first;
		@(posedge core_clk_i) disable iff (sys_rst)
		state_q == ST_ROM && !sys_rst |-> exec_addr_o == ROM_START ##1 state_q == ST_CHECK;
	endproperty
	a_rom_first: assert property (p_rom_first) else $error("boot did not start at rom"); // RULE1
	property p_jtag_req;
		@(posedge core_clk_i) disable iff (sys_rst)
		state_q == ST_CHECK && spe_rd && pss_rd == SRC_JTAG |=> loader_active_o && loader_src_o == SRC_JTAG;
	endproperty
	a_jtag_req: assert property (p_jtag_req) else $error("jtag request not honoured"); // RULE2
	property p_app_direct;
		@(posedge core_clk_i) disable iff (sys_rst)
		state_q == ST_CHECK && !spe_rd && pwd_set |=> app_run_o && exec_addr_o == APP_START;
	endproperty
	a_app_direct: assert property (p_app_direct) else $error("no direct application start"); // RULE3
	property p_baud_hit;
		@(posedge core_clk_i) disable iff (sys_rst)
		state_q == ST_WAIT_BAUD && host_byte_valid_i && host_byte_i == AUTOBAUD_CHAR
			|=> tx_valid_o && tx_data_o == PROMPT_CHAR && loader_src_o == SRC_UART ##1 !tx_valid_o;
	endproperty
	a_baud_hit: assert property (p_baud_hit) else $error("autobaud not answered"); // RULE6
	property p_baud_timeout;
		@(posedge core_clk_i) disable iff (sys_rst)
		state_q == ST_WAIT_BAUD && baud_tmo && !host_byte_valid_i |=> app_run_o;
	endproperty
	a_baud_timeout: assert property (p_baud_timeout) else $error("timeout did not start app"); // RULE5
	property p_fam_lock;
		@(posedge core_clk_i) disable iff (sys_rst)
		state_q == ST_LOADER && host_byte_valid_i && host_byte_i[7:4] != 4'h0 && lock_q
			|=> status_o == STAT_NO_PWD && tx_valid_o && !cmd_fwd_valid_o;
	endproperty
	a_fam_lock: assert property (p_fam_lock) else $error("locked command accepted"); // RULE7
	property p_read_or;
		@(posedge core_clk_i) disable iff (sys_rst)
		reg_rd_i && reg_addr_i == OFS_FLAGS
			|=> reg_rdata_o[3:1] == {$past(cpu_pss_q | tap_pss_q), $past(cpu_spe_q | tap_spe_q)}
			&& reg_rdata_o[7:4] == 4'h0;
	endproperty
	a_read_or: assert property (p_read_or) else $error("flag read not or of copies"); // RULE15 RULE18
	property p_cpu_wr_clears;
		@(posedge core_clk_i) disable iff (flag_rst)
		wr_flags && !tap_pss_wr_i |=> tap_pss_q == 2'h0;
	endproperty
	a_cpu_wr_clears: assert property (p_cpu_wr_clears) else $error("tap source copy kept"); // RULE17
	property p_rod_spe;
		@(posedge core_clk_i) disable iff (flag_rst)
		rod_set && !tap_spe_wr_i |=> !tap_spe_q;
	endproperty
	a_rod_spe: assert property (p_rod_spe) else $error("tap enable kept after done"); // RULE21
	property p_rod_reset;
		@(posedge core_clk_i) disable iff (sys_rst)
		rod_set && spe_rd |=> sys_reset_req_o ##1 !sys_reset_req_o;
	endproperty
	a_rod_reset: assert property (p_rod_reset) else $error("no system reset on done"); // RULE23
	property p_pwd_wrong;
		@(posedge core_clk_i) disable iff (sys_rst)
		s_bad_pwd |=> s_lock_set;
	endproperty
	a_pwd_wrong: assert property (p_pwd_wrong) else $error("wrong password left unlocked"); // RULE10
	property p_pwd_good;
		@(posedge core_clk_i) disable iff (sys_rst)
		pw.done && pw.match && !wr_sc |=> !lock_q;
	endproperty
	a_pwd_good: assert property (p_pwd_good) else $error("good password left locked"); // RULE9
	property p_keep_spe;
		@(posedge core_clk_i) disable iff (flag_rst)
		rst_i && !reg_wr_i |=> cpu_spe_q == $past(cpu_spe_q) && cpu_pss_q == $past(cpu_pss_q);
	endproperty
	a_keep_spe: assert property (p_keep_spe) else $error("system reset cleared flags"); // RULE16 RULE20
endmodule

// File: isp_boot_source_control_bench.sv
// Self-checking bench: flag register, boot paths and loader command gate.
// Assumes a shortened autobaud window and the host model on the byte link.
`timescale 1ns/1ps
module isp_boot_source_control_bench;
	import isp_boot_pkg::*;
	// ----
	// Signals
	// ----
	localparam int unsigned WAIT_CYC = 50;
	localparam int W_APP = 0, W_LDR = 1, W_TX = 2, W_FWD = 3, W_ERA = 4, W_SRST = 5;
	logic core_clk_i, rst_i, por_i, tlr_i, reg_wr_i, reg_rd_i, tap_pss_wr_i, tap_spe_wr_i, tap_spe_i;
	logic rod_clear_i, host_byte_valid_i, cmd_done_i, erase_done_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, host_byte_i, tx_data_o, cmd_fwd_byte_o, status_o;
	logic [1:0] tap_pss_i, loader_src_o;
	logic [255:0] stored_pwd_i;
	logic [15:0] exec_addr_o;
	logic app_run_o, loader_active_o, tx_valid_o, cmd_fwd_valid_o, erase_req_o, pass_lock_flag_o, sys_reset_req_o;
	logic [5:0] flags_v;
	int error_cnt, n_compared, cnt;
	bit seen;
	assign flags_v = {sys_reset_req_o, erase_req_o, cmd_fwd_valid_o, tx_valid_o, loader_active_o, app_run_o};
	isp_boot_source_control #(.BAUD_WAIT_CYCLES(WAIT_CYC)) u_dut (.core_clk_i, .rst_i, .por_i, .tlr_i,
		.reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .tap_pss_wr_i, .tap_pss_i,
		.tap_spe_wr_i, .tap_spe_i, .rod_clear_i, .stored_pwd_i, .host_byte_valid_i, .host_byte_i,
		.cmd_done_i, .erase_done_i, .exec_addr_o, .app_run_o, .loader_active_o, .loader_src_o,
		.tx_valid_o, .tx_data_o, .cmd_fwd_valid_o, .cmd_fwd_byte_o, .erase_req_o, .status_o,
		.pass_lock_flag_o, .sys_reset_req_o);
	host_model u_host (.core_clk_i(core_clk_i), .host_byte_valid_o(host_byte_valid_i), .host_byte_o(host_byte_i));
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input string what, input logic [15:0] seen_v, input logic [15:0] exp_v);
		n_compared++;
		if (seen_v !== exp_v) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp_v, seen_v);
		end
	endtask
	task automatic complete_run;
		$display("Mismatches %0d of %0d compared", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Looks once before the next edge so a one-cycle pulse launched on the last edge is not missed
	task automatic wait_hi(input int b, input int lim);
		cnt = 0;
		#1;
		seen = (flags_v[b] === 1'b1);
		while (cnt < lim && !seen) begin
			@(posedge core_clk_i);
			#1;
			cnt++;
			seen = (flags_v[b] === 1'b1);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp_v);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("reg_rdata", {8'h00, reg_rdata_o}, {8'h00, exp_v});
	endtask
	task automatic boot(input logic [7:0] flg);
		wr(OFS_FLAGS, flg);
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk("exec_rom", exec_addr_o, ROM_START);
		@(posedge core_clk_i);
		rst_i <= 1'b0;
	endtask
	// Status is skipped when the expected value is left unknown
	task automatic prompt(input logic [7:0] st);
		wait_hi(W_TX, 40);
		chk("prompt", {7'h00, seen, tx_data_o}, {8'h01, PROMPT_CHAR});
		if (!$isunknown(st)) chk("status", {8'h00, status_o}, {8'h00, st});
	endtask
	task automatic fwd(input logic [7:0] c);
		u_host.send(c);
		wait_hi(W_FWD, 5);
		chk("fwd", {7'h00, seen, cmd_fwd_byte_o}, {8'h01, c});
		@(posedge core_clk_i);
		cmd_done_i <= 1'b1;
		@(posedge core_clk_i);
		cmd_done_i <= 1'b0;
		prompt('x);
	endtask
	// ----
	// Tests
	// ----
	initial begin
		#100000;
		error_cnt++;
		complete_run();
	end
	initial begin
		{rst_i, por_i, tlr_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {2'h3, 19'h00000};
		{tap_pss_wr_i, tap_pss_i, tap_spe_wr_i, tap_spe_i, rod_clear_i} = 6'h00;
		{stored_pwd_i, cmd_done_i, erase_done_i} = '0;
		error_cnt = 0;
		n_compared = 0;
		repeat (20) @(posedge core_clk_i);
		#1;
		chk("exec_por", exec_addr_o, ROM_START);
		chk("lock_por", pass_lock_flag_o, 1);
		@(posedge core_clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		wait_hi(W_APP, WAIT_CYC + 30);
		chk("late_app", {seen, cnt >= WAIT_CYC}, 2'h3);
		chk("no_baud", {exec_addr_o, status_o}, {APP_START, STAT_NO_BAUD});
		rd(OFS_FLAGS, FLAGS_RESET);
		wr(OFS_FLAGS, 8'hFF);
		rd(OFS_FLAGS, 8'h0F);
		@(posedge core_clk_i);
		tlr_i <= 1'b1;
		@(posedge core_clk_i);
		tlr_i <= 1'b0;
		rd(OFS_FLAGS, 8'h00);
		@(posedge core_clk_i);
		{tap_pss_wr_i, tap_pss_i, tap_spe_wr_i, tap_spe_i} <= {1'b1, SRC_UART, 2'h3};
		@(posedge core_clk_i);
		{tap_pss_wr_i, tap_spe_wr_i} <= 2'h0;
		rd(OFS_FLAGS, 8'h06);
		wr(OFS_FLAGS, 8'h00);
		rd(OFS_FLAGS, 8'h02);
		wr(OFS_SYSCTL, 8'h06);
		wait_hi(W_SRST, 3);
		chk("sys_reset", seen, 1);
		rd(OFS_SYSCTL, 8'h06);
		rd(OFS_FLAGS, 8'h00);
		@(posedge core_clk_i);
		rod_clear_i <= 1'b1;
		@(posedge core_clk_i);
		rod_clear_i <= 1'b0;
		boot(8'h02);
		wait_hi(W_LDR, 10);
		chk("jtag", {seen, loader_src_o}, {1'b1, SRC_JTAG});
		rd(OFS_FLAGS, 8'h02);
		boot(8'h0A);
		wait_hi(W_APP, 10);
		chk("reserved_app", seen, 1);
		@(posedge core_clk_i) stored_pwd_i <= {16{16'h5AC3}};
		boot(8'h00);
		wait_hi(W_APP, 10);
		chk("pwd_app", {seen, exec_addr_o}, {1'b1, APP_START});
		@(posedge core_clk_i) stored_pwd_i <= '0;
		boot(8'h06);
		// The window opens only after the boot check, so the first edge is let pass
		@(posedge core_clk_i);
		u_host.send(AUTOBAUD_CHAR);
		prompt(STAT_OK);
		chk("uart", {loader_active_o, loader_src_o}, {1'b1, SRC_UART});
		u_host.send(8'h10);
		prompt(STAT_NO_PWD);
		u_host.send(8'h07);
		prompt(STAT_BAD_CMD);
		u_host.send(CMD_NOP);
		prompt(STAT_OK);
		wr(OFS_SYSCTL, 8'h00);
		fwd(8'h10);
		u_host.send_pwd({32{8'hA5}});
		prompt(STAT_NO_PWD);
		chk("lock_wrong", pass_lock_flag_o, 1);
		u_host.send_pwd('0);
		prompt(STAT_OK);
		chk("lock_match", pass_lock_flag_o, 0);
		fwd(8'h21);
		fwd(CMD_STATUS);
		wr(OFS_SYSCTL, 8'h02);
		u_host.send(CMD_ERASE);
		wait_hi(W_ERA, 5);
		chk("erase_req", seen, 1);
		@(posedge core_clk_i);
		erase_done_i <= 1'b1;
		@(posedge core_clk_i);
		erase_done_i <= 1'b0;
		prompt(STAT_OK);
		chk("lock_erase", pass_lock_flag_o, 0);
		u_host.send(CMD_EXIT);
		wait_hi(W_TX, 4);
		chk("exit_quiet", {seen, loader_active_o}, 2'h0);
		u_host.send(AUTOBAUD_CHAR);
		prompt(STAT_OK);
		chk("reenter", loader_active_o, 1);
		@(posedge core_clk_i) stored_pwd_i <= {16{16'h5AC3}};
		u_host.send(CMD_EXIT);
		wait_hi(W_APP, 3);
		chk("exit_app", {seen, exec_addr_o}, {1'b1, APP_START});
		complete_run();
	end
endmodule

// File: pwd_compare.sv
// Compares 32 received bytes with the stored password, low byte of each word first.
// Assumes the stored password is stable while a comparison runs.
`timescale 1ns/1ps
module pwd_compare
	import isp_boot_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [255:0] stored_pwd_i,
	pwd_if.cmp pw
);
	logic [5:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	logic bad_q, bad_d;
	logic done_q, done_d;
	logic match_q, match_d;
	logic miss;

	always_comb begin
		miss = pw.byte_data != stored_pwd_i[{cnt_q[4:0], 3'b000} +: 8];
		cnt_d = cnt_q;
		busy_d = busy_q;
		bad_d = bad_q;
		done_d = 1'b0;
		match_d = match_q;
		if (pw.start) begin
			cnt_d = 6'h00;
			busy_d = 1'b1;
			bad_d = 1'b0;
		end else if (busy_q && pw.byte_valid) begin
			bad_d = bad_q | miss;
			cnt_d = 6'(cnt_q + 6'h01);
			if (cnt_q == 6'(PWD_BYTES - 6'h01)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				match_d = !(bad_q | miss); // RULE9
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt_q <= 6'h00;
			busy_q <= 1'b0;
			bad_q <= 1'b0;
			done_q <= 1'b0;
			match_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			bad_q <= bad_d;
			done_q <= done_d;
			match_q <= match_d;
		end
	end

	assign pw.done = done_q;
	assign pw.match = match_q;
endmodule

// File: pwd_if.sv
// Byte stream from the loader sequencer into the password comparator.
// Both ends sit on the core clock.
`timescale 1ns/1ps
interface pwd_if;
	logic start;
	logic byte_valid;
	logic [7:0] byte_data;
	logic done;
	logic match;
	modport ctrl(output start, output byte_valid, output byte_data, input done, input match);
	modport cmp(input start, input byte_valid, input byte_data, output done, output match);
endinterface
